// ==== src/srt_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srt_params.svh"

// Functional notes
// - Five independent 16-bit channels, identical apart from the timer gate option.
// - Two-bit mode field selects timer or event mode; one-shot and PWM codes stop counting.
// - Timer mode counts clock tap divided by 1, 2, 8 or 32.
// - Timer mode counts down, reloads on underflow, raises interrupt request.
// - Timer divide ratio is 1/(n+1) over full 16-bit range.
// - Run bit in shared start flags starts and stops each channel.
// - Stopped or before first tick, count write loads reload and counter.
// - After first tick, count write loads reload only, used at next reload.
// - Reading count value returns live counter contents.
// - Gate option lets input pin level suspend counting, not on channels 2, 3.
// - Timer pulse output inverts on underflow, held low while stopped.
// - Event source is pin edge, previous or next channel wrap, ring order.
// - Event direction from software bit or output pin level.
// - Event mode reloads on wrap unless free-run selected.
// - Event ratio 1/(FFFFh-n+1) counting up, 1/(n+1) counting down.
// - Event mode raises interrupt request on every overflow and underflow.
// - Event output pin is general port, pulse output or direction input.
// - Event pulse output inverts on wrap, held low while stopped.

module srt_timer #(
  parameter int CHANNELS = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] channel_input_pin,
  input wire logic [CHANNELS-1:0] channel_output_pin_in,
  output logic [CHANNELS-1:0] channel_output_pin_out,
  output logic [CHANNELS-1:0] channel_output_pin_oe,
  output logic [CHANNELS-1:0] irq_req
);
  import srt_pkg::*;

  // Ring wiring and the gate-less channels assume exactly five channels
  if (CHANNELS != 5) begin : g_bad_channels
    $error("srt_timer supports exactly five channels");
  end

  typedef struct packed {
    logic [CHANNELS-1:0] run;
    logic [CHANNELS-1:0][`SRT_MODE_WIDTH-1:0] mode;
    logic [CHANNELS-1:0] in_s1;
    logic [CHANNELS-1:0] in_s2;
    logic [CHANNELS-1:0] dir_s1;
    logic [CHANNELS-1:0] dir_s2;
    logic [4:0] pre;
    logic [31:0] rdata;
    logic err;
  } srt_top_state_t;

  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } srt_decode_t;

  srt_top_state_t q;
  srt_top_state_t next_q;
  srt_chan_out_t [CHANNELS-1:0] ch_out;
  logic [CHANNELS-1:0] wr_count;
  logic [CHANNELS-1:0] wrap;
  logic [CHANNELS-1:0] tap_tick;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic srt_decode_t region_hit(input logic [11:0] addr, input logic [11:0] base);
    srt_decode_t d;
    d.idx = addr[4:2];
    d.hit = ((addr & `SRT_REGION_MASK) == base) && (addr[1:0] == 2'b00) && (addr[4:2] < 3'(CHANNELS));
    return d;
  endfunction : region_hit

  function automatic logic tap_select(input srt_tap_t tap, input logic [4:0] pre);
    logic t;
    unique case (tap)
      SRT_TAP_UNDIVIDED: t = 1'b1;
      SRT_TAP_HALF: t = (pre[0] == 1'(`SRT_PRE_HALF));
      SRT_TAP_EIGHTH: t = (pre[2:0] == 3'(`SRT_PRE_EIGHTH));
      SRT_TAP_THIRTY_SECOND: t = (pre == `SRT_PRE_THIRTY_SECOND);
    endcase
    return t;
  endfunction : tap_select

  srt_decode_t mode_dec;
  srt_decode_t count_dec;
  logic setup;
  logic access_wr;

  assign mode_dec = region_hit(paddr, `SRT_MODE_BASE);
  assign count_dec = region_hit(paddr, `SRT_COUNT_BASE);
  assign setup = psel && !penable;
  assign access_wr = psel && penable && pwrite && !q.err;

  // ****************************************
  // Register file and synchronisers
  // ****************************************
  always_comb begin
    logic start_hit;
    logic status_hit;
    start_hit = (paddr == `SRT_START_OFS);
    status_hit = (paddr == `SRT_STATUS_OFS);
    next_q = q;
    next_q.in_s1 = channel_input_pin;
    next_q.in_s2 = q.in_s1;
    next_q.dir_s1 = channel_output_pin_in;
    next_q.dir_s2 = q.dir_s1;
    next_q.pre = q.pre + 5'h01;
    wr_count = '0;
    if (setup) begin
      next_q.err = !(start_hit || (status_hit && !pwrite) || mode_dec.hit || count_dec.hit);
      next_q.rdata = 32'h0000_0000;
      if (pwrite) begin
        // Write cycles return zero read data
        next_q.rdata = 32'h0000_0000;
      end else if (start_hit) begin
        next_q.rdata[CHANNELS-1:0] = q.run;
      end else if (status_hit) begin
        for (int i = 0; i < CHANNELS; i++) begin
          next_q.rdata[`SRT_STAT_OUT_LSB + i] = ch_out[i].out_level;
          next_q.rdata[`SRT_STAT_BEGUN_LSB + i] = ch_out[i].begun;
        end
      end else if (mode_dec.hit) begin
        next_q.rdata[`SRT_MODE_WIDTH-1:0] = q.mode[mode_dec.idx];
      end else if (count_dec.hit) begin
        next_q.rdata[15:0] = ch_out[count_dec.idx].count;
      end
    end
    if (access_wr) begin
      if (paddr == `SRT_START_OFS) begin
        next_q.run = pwdata[CHANNELS-1:0];
      end else if (mode_dec.hit) begin
        next_q.mode[mode_dec.idx] = pwdata[`SRT_MODE_WIDTH-1:0];
      end else if (count_dec.hit) begin
        wr_count[count_dec.idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.err;

  // ****************************************
  // Channels
  // ****************************************
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    srt_cfg_t cfg;
    srt_chan_in_t cin;
    assign cfg = srt_cfg_t'(q.mode[i]);
    assign tap_tick[i] = tap_select(cfg.tap, q.pre);
    assign cin.pin_in = q.in_s2[i];
    assign cin.dir_in = q.dir_s2[i];
    assign cin.prev_wrap = wrap[(i + CHANNELS - 1) % CHANNELS];
    assign cin.next_wrap = wrap[(i + 1) % CHANNELS];
    assign cin.tap_tick = tap_tick[i];
    assign wrap[i] = ch_out[i].wrap;

    srt_channel #(
      .HAS_GATE((i != 2) && (i != 3))
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .run(q.run[i]),
      .cin(cin),
      .wr_en(wr_count[i]),
      .wr_data(pwdata[15:0]),
      .cout(ch_out[i])
    );

    assign channel_output_pin_out[i] = ch_out[i].out_level;
    assign channel_output_pin_oe[i] = ch_out[i].out_oe;
    assign irq_req[i] = ch_out[i].wrap;
  end

endmodule : srt_timer

`default_nettype wire

// ==== shared/srt_params.svh ====
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH

// Register offsets (byte addresses)
`define SRT_START_OFS 12'h000
`define SRT_STATUS_OFS 12'h004
`define SRT_MODE_BASE 12'h020
`define SRT_COUNT_BASE 12'h040
`define SRT_REGION_MASK 12'hFE0

// Mode control field positions
`define SRT_MODE_LSB 0
`define SRT_TAP_LSB 2
`define SRT_GATE_BIT 4
`define SRT_PULSE_BIT 5
`define SRT_SRC_LSB 6
`define SRT_EDGE_BIT 8
`define SRT_DIREXT_BIT 9
`define SRT_SWUP_BIT 10
`define SRT_FREE_BIT 11
`define SRT_MODE_WIDTH 12

// Status field positions
`define SRT_STAT_OUT_LSB 0
`define SRT_STAT_BEGUN_LSB 8

// Reset values and count maximum
`define SRT_COUNT_RESET 16'h0000
`define SRT_MODE_RESET 12'h000
`define SRT_COUNT_MAX 16'hFFFF

// Prescaler terminal counts
`define SRT_PRE_HALF 5'h01
`define SRT_PRE_EIGHTH 5'h07
`define SRT_PRE_THIRTY_SECOND 5'h1F

`endif

// ==== shared/srt_pkg.sv ====
package srt_pkg;

  typedef enum logic [1:0] {
    SRT_MODE_TIMER = 2'b00,
    SRT_MODE_EVENT = 2'b01,
    SRT_MODE_ONE_SHOT = 2'b10,
    SRT_MODE_PWM = 2'b11
  } srt_mode_t;

  typedef enum logic [1:0] {
    SRT_TAP_UNDIVIDED = 2'b00,
    SRT_TAP_HALF = 2'b01,
    SRT_TAP_EIGHTH = 2'b10,
    SRT_TAP_THIRTY_SECOND = 2'b11
  } srt_tap_t;

  typedef enum logic [1:0] {
    SRT_SRC_PIN = 2'b00,
    SRT_SRC_PREV = 2'b01,
    SRT_SRC_NEXT = 2'b10,
    SRT_SRC_NONE = 2'b11
  } srt_src_t;

  // Layout matches the mode control register, msb first
  typedef struct packed {
    logic free_run;
    logic sw_up;
    logic dir_ext;
    logic edge_rise;
    srt_src_t src;
    logic pulse_en;
    logic gate_en;
    srt_tap_t tap;
    srt_mode_t mode;
  } srt_cfg_t;

  typedef struct packed {
    logic pin_in;
    logic dir_in;
    logic prev_wrap;
    logic next_wrap;
    logic tap_tick;
  } srt_chan_in_t;

  typedef struct packed {
    logic [15:0] count;
    logic wrap;
    logic out_level;
    logic out_oe;
    logic begun;
  } srt_chan_out_t;

endpackage : srt_pkg

// ==== src/srt_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srt_params.svh"

module srt_channel #(
  parameter bit HAS_GATE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire srt_pkg::srt_cfg_t cfg,
  input wire logic run,
  input wire srt_pkg::srt_chan_in_t cin,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output srt_pkg::srt_chan_out_t cout
);
  import srt_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic begun;
    logic toggle;
    logic wrap;
    logic pin_prev;
  } srt_chan_state_t;

  srt_chan_state_t q;
  srt_chan_state_t next_q;

  // ****************************************
  // Count logic
  // ****************************************
  always_comb begin
    logic active;
    logic gate_ok;
    logic edge_seen;
    logic source;
    logic up;
    logic tick;
    next_q = q;
    next_q.wrap = 1'b0;
    next_q.pin_prev = cin.pin_in;
    active = run && (cfg.mode == SRT_MODE_TIMER || cfg.mode == SRT_MODE_EVENT);
    gate_ok = !(HAS_GATE && cfg.gate_en) || cin.pin_in;
    edge_seen = cfg.edge_rise ? (cin.pin_in && !q.pin_prev) : (!cin.pin_in && q.pin_prev);
    source = 1'b0;
    up = 1'b0;
    if (cfg.mode == SRT_MODE_TIMER) begin
      source = cin.tap_tick && gate_ok;
    end else begin
      unique case (cfg.src)
        SRT_SRC_PIN: source = edge_seen;
        SRT_SRC_PREV: source = cin.prev_wrap;
        SRT_SRC_NEXT: source = cin.next_wrap;
        SRT_SRC_NONE: source = 1'b0;
      endcase
      up = cfg.dir_ext ? cin.dir_in : cfg.sw_up;
    end
    tick = active && source;
    if (!run) begin
      next_q.begun = 1'b0;
      next_q.toggle = 1'b0;
    end
    if (tick) begin
      next_q.begun = 1'b1;
      if (up) begin
        if (q.count == `SRT_COUNT_MAX) begin
          next_q.wrap = 1'b1;
          next_q.count = cfg.free_run ? (q.count + 16'h0001) : q.reload;
        end else begin
          next_q.count = q.count + 16'h0001;
        end
      end else begin
        if (q.count == `SRT_COUNT_RESET) begin
          next_q.wrap = 1'b1;
          next_q.count = (cfg.mode == SRT_MODE_EVENT && cfg.free_run) ? (q.count - 16'h0001) : q.reload;
        end else begin
          next_q.count = q.count - 16'h0001;
        end
      end
      if (next_q.wrap && cfg.pulse_en) begin
        next_q.toggle = !q.toggle;
      end
    end
    if (wr_en) begin
      next_q.reload = wr_data;
      if (!q.begun) begin
        next_q.count = wr_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_comb begin
    cout.count = q.count;
    cout.wrap = q.wrap;
    cout.out_level = q.toggle;
    cout.out_oe = cfg.pulse_en && !(cfg.mode == SRT_MODE_EVENT && cfg.dir_ext);
    cout.begun = q.begun;
  end

endmodule : srt_channel

`default_nettype wire

// ==== bench/srt_timer_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module srt_timer_properties #(
  parameter int CHANNELS = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] channel_input_pin,
  input wire logic [CHANNELS-1:0] channel_output_pin_in,
  input wire logic [CHANNELS-1:0] channel_output_pin_out,
  input wire logic [CHANNELS-1:0] channel_output_pin_oe,
  input wire logic [CHANNELS-1:0] irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  property p_err_phase; pslverr |-> psel && penable; endproperty
  property p_count_ok; psel && penable && paddr == 12'h040 |-> !pslverr; endproperty
  property p_status_ro; psel && penable && pwrite && paddr == 12'h004 |-> pslverr; endproperty
  property p_wr_zero; psel && penable && pwrite |-> prdata == 32'h0000_0000; endproperty
  property p_reset;
    disable iff (1'b0) !presetn |-> irq_req == '0 && channel_output_pin_out == '0 && channel_output_pin_oe == '0;
  endproperty
  property p_toggle;
    (irq_req & channel_output_pin_oe & $past(channel_output_pin_oe)
      & ~(channel_output_pin_out ^ $past(channel_output_pin_out))) == '0;
  endproperty
  property p_rise; (channel_output_pin_out & ~$past(channel_output_pin_out) & ~irq_req) == '0; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  a_count_ok: assert property (p_count_ok) else $error("count read refused");
  a_status_ro: assert property (p_status_ro) else $error("status write accepted");
  a_wr_zero: assert property (p_wr_zero) else $error("prdata not zero on write");
  a_reset: assert property (p_reset) else $error("outputs active in reset");
  a_toggle: assert property (p_toggle) else $error("output kept level on wrap");
  a_rise: assert property (p_rise) else $error("output rose without wrap");
  cover property (irq_req[0]);
  cover property (irq_req[4]);
  cover property (pslverr);
endmodule : srt_timer_properties
bind srt_timer srt_timer_properties #(.CHANNELS(CHANNELS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_input_pin(channel_input_pin),
  .channel_output_pin_in(channel_output_pin_in), .channel_output_pin_out(channel_output_pin_out),
  .channel_output_pin_oe(channel_output_pin_oe), .irq_req(irq_req)
);
`default_nettype wire

// ==== bench/srt_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// External pulse sources and pin wiring
// ****
module srt_pulse_src (
  input wire logic pclk,
  input wire logic [4:0] kick,
  input wire logic [4:0] gate,
  input wire logic [4:0] dir,
  input wire logic [4:0] drv,
  input wire logic [4:0] oe,
  output logic [4:0] in_pin,
  output logic [4:0] out_pin
);
  logic [2:0] sh [5] = '{default: 3'b000};
  // Each kick gives a pulse three cycles wide
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 5; i++) sh[i] <= kick[i] ? 3'b111 : sh[i] >> 1;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) in_pin[i] = gate[i] | sh[i][0];
  end
  assign out_pin = (oe & drv) | (~oe & dir);
endmodule : srt_pulse_src
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srt_pkg::*;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rs = 32'h0000_3b80, v;
  logic [4:0] kick = 0, gate = 0, dir = 0, pin_in, opin_in, opin_out, opin_oe, irq;
  logic [32:0] q[$];
  int miscompares = 0, n_compared = 0, p, cnt[5];
  int dv[4] = '{1, 2, 8, 32};
  logic [31:0] em[4] = '{32'h0000_0101, 32'h0000_0521, 32'h0000_0301, 32'h0000_0801};
  logic [15:0] en[4] = '{16'h0002, 16'hfffd, 16'hfffd, 16'h0002};
  logic [15:0] ec[4] = '{16'h0002, 16'hfffd, 16'hfffd, 16'hffff};
  srt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_input_pin(pin_in), .channel_output_pin_in(opin_in), .channel_output_pin_out(opin_out),
    .channel_output_pin_oe(opin_oe), .irq_req(irq));
  srt_pulse_src ps (.pclk(pclk), .kick(kick), .gate(gate), .dir(dir), .drv(opin_out), .oe(opin_oe),
    .in_pin(pin_in), .out_pin(opin_in));
  initial forever #20 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic xfer(input logic w, input int a, input logic [31:0] d, input logic [31:0] ed, input logic ee);
    q.push_back({ee, ed});
    psel <= 1;
    pwrite <= w;
    paddr <= 12'(a);
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : xfer
  task automatic per(input int ch, output int n);
    while (irq[ch] !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    n = 1;
    while (irq[ch] !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask : per
  always @(posedge pclk) begin : mon
    logic [32:0] e;
    for (int i = 0; i < 5; i++) if (irq[i] === 1'b1) cnt[i]++;
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      chk(prdata, e[31:0]);
      chk(32'(pslverr), 32'(e[32]));
    end
  end
  initial begin
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      xfer(0, 12'h040 + 4 * i, 0, 0, 0);
      xfer(0, 12'h020 + 4 * i, 0, 0, 0);
    end
    xfer(0, 12'h004, 0, 0, 0);
    xfer(0, 12'h100, 0, 0, 1);
    xfer(1, 12'h004, 1, 0, 1);
    for (int i = 0; i < 5; i++) begin
      v = rnd();
      xfer(1, 12'h040 + 4 * i, v, 0, 0);
      xfer(0, 12'h040 + 4 * i, 0, {16'h0000, v[15:0]}, 0);
    end
    $display("test reset and load done");
    for (int t = 0; t < 4; t++) begin
      xfer(1, 12'h020, 32'h0000_0020 | (32'(t) << 2), 0, 0);
      xfer(1, 12'h040, 3, 0, 0);
      xfer(1, 12'h000, 1, 0, 0);
      per(0, p);
      chk(p, 4 * dv[t]);
      xfer(1, 12'h000, 0, 0, 0);
      @(posedge pclk);
      chk(32'(opin_out[0]), 0);
    end
    $display("test timer taps done");
    xfer(1, 12'h000, 1, 0, 0);
    per(0, p);
    xfer(1, 12'h040, 9, 0, 0);
    xfer(0, 12'h040, 0, 3, 0);
    per(0, p);
    per(0, p);
    chk(p, 10 * dv[3]);
    xfer(1, 12'h000, 0, 0, 0);
    cnt = '{default: 0};
    repeat (400) @(posedge pclk);
    chk(cnt[0], 0);
    xfer(1, 12'h024, 32'h0000_0010, 0, 0);
    xfer(1, 12'h028, 32'h0000_0010, 0, 0);
    xfer(1, 12'h044, 1, 0, 0);
    xfer(1, 12'h048, 1, 0, 0);
    xfer(1, 12'h000, 32'h0000_0006, 0, 0);
    repeat (30) @(posedge pclk);
    chk(cnt[1], 0);
    chk(32'(cnt[2] > 0), 1);
    gate <= 5'h02;
    repeat (30) @(posedge pclk);
    chk(32'(cnt[1] > 0), 1);
    xfer(1, 12'h000, 0, 0, 0);
    gate <= 5'h00;
    $display("test reload, stop and gate done");
    xfer(1, 12'h028, 32'h0000_0081, 0, 0);
    xfer(1, 12'h048, 0, 0, 0);
    xfer(1, 12'h030, 32'h0000_0041, 0, 0);
    xfer(1, 12'h050, 0, 0, 0);
    for (int c = 0; c < 4; c++) begin
      dir <= em[c][9] ? 5'h08 : 5'h00;
      xfer(1, 12'h02c, em[c], 0, 0);
      xfer(1, 12'h04c, {16'h0000, en[c]}, 0, 0);
      xfer(1, 12'h000, 32'h0000_001c, 0, 0);
      cnt = '{default: 0};
      for (int k = 0; k < 3; k++) begin
        chk(cnt[3], 0);
        kick <= 5'h08;
        @(posedge pclk) kick <= 5'h00;
        repeat (8) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      chk(cnt[3], 1);
      chk(cnt[4], 1);
      chk(cnt[2], 1);
      chk(32'(opin_out[3]), 32'(em[c][5]));
      xfer(0, 12'h04c, 0, {16'h0000, ec[c]}, 0);
      xfer(1, 12'h000, 0, 0, 0);
    end
    $display("test event counter done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
